//--- include/uart_reset_pkg.sv
// Purpose: Shared constants for the UART channel reset-default block
// Assumes: AXI4-Lite register bus, 32-bit data, one register per aligned word
// Notes: Offsets are byte addresses on the register bus
package uart_reset_pkg;
  localparam int channel_count = 8;
  localparam logic [7:0] off_divisor_low = 8'h00;
  localparam logic [7:0] off_divisor_high = 8'h04;
  localparam logic [7:0] off_divisor_fraction = 8'h08;
  localparam logic [7:0] off_holding = 8'h0c;
  localparam logic [7:0] off_interrupt_enable = 8'h10;
  localparam logic [7:0] off_fifo_control = 8'h14;
  localparam logic [7:0] off_interrupt_status = 8'h18;
  localparam logic [7:0] off_line_control = 8'h1c;
  localparam logic [7:0] off_modem_control = 8'h20;
  localparam logic [7:0] off_line_status = 8'h24;
  localparam logic [7:0] off_modem_status = 8'h28;
  localparam logic [7:0] off_scratchpad = 8'h2c;
  localparam logic [7:0] off_feature_control = 8'h30;
  localparam logic [7:0] off_enhanced_feature = 8'h34;
  localparam logic [7:0] off_transmit_fifo_level = 8'h38;
  localparam logic [7:0] off_transmit_trigger_level = 8'h3c;
  localparam logic [7:0] off_receive_fifo_level = 8'h40;
  localparam logic [7:0] off_receive_trigger_level = 8'h44;
  localparam logic [7:0] off_flow_char_status = 8'h48;
  localparam logic [7:0] off_resume_char_one = 8'h4c;
  localparam logic [7:0] off_resume_char_two = 8'h50;
  localparam logic [7:0] off_pause_char_one = 8'h54;
  localparam logic [7:0] off_pause_char_two = 8'h58;
  localparam logic [7:0] off_control_event = 8'h5c;
  localparam logic [7:0] rst_divisor_low = 8'h01;
  localparam logic [7:0] rst_zero = 8'h00;
  localparam logic [7:0] rst_interrupt_status = 8'h01;
  localparam logic [7:0] rst_line_status = 8'h60;
  localparam logic [7:0] rst_scratchpad = 8'hff;
  localparam int pause_bit = 0;
  localparam int resume_bit = 1;
  localparam int sent_pause_bit = 2;
  localparam int sent_resume_bit = 3;
  localparam int flow_status_width = 4;
  localparam int rx_flow_lsb = 0;
  localparam int tx_flow_lsb = 2;
  localparam int modem_delta_width = 4;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage

//--- verilog/input_sync.sv
// Purpose: Two-flop synchroniser for a bus of pin inputs
// Assumes: Inputs are asynchronous to aclk
// Notes: No reset, so pin levels pass through while the block is in reset
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
  parameter int width = 4
) (
  input wire logic aclk,
  input wire logic [width-1:0] async_in,
  output logic [width-1:0] sync_out
);
  logic [width-1:0] stage_one;
  logic [width-1:0] next_stage_one;
  logic [width-1:0] next_sync_out;

  always_comb
  begin
    next_stage_one = async_in;
    next_sync_out = stage_one;
  end

  always_ff @(posedge aclk)
  begin
    stage_one <= next_stage_one;
    sync_out <= next_sync_out;
  end
endmodule
`default_nettype wire

//--- verilog/reset_reg.sv
// Purpose: One 8-bit software register with a reset value and write strobe
// Assumes: Synchronous active-low reset
// Notes: Reset wins over a write in the same cycle
`timescale 1ns/1ps
`default_nettype none
module reset_reg #(
  parameter logic [7:0] reset_value = 8'h00
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic write_en,
  input wire logic [7:0] write_data,
  output logic [7:0] value
);
  logic [7:0] next_value;

  always_comb
  begin
    next_value = value;
    if (write_en)
      next_value = write_data;
    if (!aresetn)
      next_value = reset_value;
  end

  always_ff @(posedge aclk)
    value <= next_value;
endmodule
`default_nettype wire

//--- verilog/uart_channel_reset_defaults.sv
// Purpose: Reset state, output levels and flow-character status of one UART channel
// Assumes: AXI4-Lite slave, one aligned word per 8-bit register
// Notes: Holding registers have no defined reset content
`timescale 1ns/1ps
`default_nettype none
module uart_channel_reset_defaults (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] modem_inputs,
  output logic [7:0] serial_transmit_out,
  output logic [7:0] infrared_transmit_out,
  output logic [7:0] request_to_send_n,
  output logic [7:0] data_terminal_ready_n,
  output logic eeprom_clock_out,
  output logic eeprom_select_out,
  output logic eeprom_serial_in_out
);
  logic aw_held, w_held;
  logic next_aw_held, next_w_held, next_bvalid;
  logic [7:0] aw_addr, next_aw_addr;
  logic [7:0] w_byte, next_w_byte;
  logic [1:0] next_bresp, next_rresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic do_write, do_read, read_hit, flow_enabled;
  logic [7:0] read_byte;
  logic [7:0] divisor_low, divisor_high, divisor_fraction, interrupt_enable, fifo_control;
  logic [7:0] line_control, modem_control, scratchpad, feature_control, enhanced_feature;
  logic [7:0] transmit_trigger_level, receive_trigger_level;
  logic [7:0] resume_char_one, resume_char_two, pause_char_one, pause_char_two;
  logic [7:0] transmit_holding, next_transmit_holding;
  logic [uart_reset_pkg::flow_status_width-1:0] flow_char_status, next_flow_char_status;
  logic [3:0] modem_now;
  logic [3:0] modem_last, next_modem_last;
  logic [3:0] modem_delta, next_modem_delta;
  logic [7:0] control_event;
  logic [7:0] next_serial, next_infrared, next_rts_n, next_dtr_n;
  logic next_ee_clock, next_ee_select, next_ee_data;

  input_sync #(.width(4)) modem_sync (
    .aclk(aclk),
    .async_in(modem_inputs),
    .sync_out(modem_now)
  );

  // Write is performed once both address and data have been taken
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  function automatic logic wr(input logic [7:0] off);
    wr = do_write && (aw_addr == off);
  endfunction

  reset_reg #(.reset_value(uart_reset_pkg::rst_divisor_low)) divisor_low_reg (
    .aclk(aclk), .aresetn(aresetn),
    .write_en(wr(uart_reset_pkg::off_divisor_low)), .write_data(w_byte), .value(divisor_low));
  reset_reg #(.reset_value(uart_reset_pkg::rst_zero)) divisor_high_reg (
    .aclk(aclk), .aresetn(aresetn),
    .write_en(wr(uart_reset_pkg::off_divisor_high)), .write_data(w_byte), .value(divisor_high));
  reset_reg #(.reset_value(uart_reset_pkg::rst_zero)) divisor_fraction_reg (
    .aclk(aclk), .aresetn(aresetn),
    .write_en(wr(uart_reset_pkg::off_divisor_fraction)), .write_data(w_byte),
    .value(divisor_fraction));
  reset_reg #(.reset_value(uart_reset_pkg::rst_zero)) interrupt_enable_reg (
    .aclk(aclk), .aresetn(aresetn),
    .write_en(wr(uart_reset_pkg::off_interrupt_enable)), .write_data(w_byte),
    .value(interrupt_enable));
  reset_reg #(.reset_value(uart_reset_pkg::rst_zero)) fifo_control_reg (
    .aclk(aclk), .aresetn(aresetn),
    .write_en(wr(uart_reset_pkg::off_fifo_control)), .write_data(w_byte), .value(fifo_control));
  reset_reg #(.reset_value(uart_reset_pkg::rst_zero)) line_control_reg (
    .aclk(aclk), .aresetn(aresetn),
    .write_en(wr(uart_reset_pkg::off_line_control)), .write_data(w_byte), .value(line_control));
  reset_reg #(.reset_value(uart_reset_pkg::rst_zero)) modem_control_reg (
    .aclk(aclk), .aresetn(aresetn),
    .write_en(wr(uart_reset_pkg::off_modem_control)), .write_data(w_byte),
    .value(modem_control));
  reset_reg #(.reset_value(uart_reset_pkg::rst_scratchpad)) scratchpad_reg (
    .aclk(aclk), .aresetn(aresetn),
    .write_en(wr(uart_reset_pkg::off_scratchpad)), .write_data(w_byte), .value(scratchpad));
  reset_reg #(.reset_value(uart_reset_pkg::rst_zero)) feature_control_reg (
    .aclk(aclk), .aresetn(aresetn),
    .write_en(wr(uart_reset_pkg::off_feature_control)), .write_data(w_byte),
    .value(feature_control));
  reset_reg #(.reset_value(uart_reset_pkg::rst_zero)) enhanced_feature_reg (
    .aclk(aclk), .aresetn(aresetn),
    .write_en(wr(uart_reset_pkg::off_enhanced_feature)), .write_data(w_byte),
    .value(enhanced_feature));
  reset_reg #(.reset_value(uart_reset_pkg::rst_zero)) transmit_trigger_reg (
    .aclk(aclk), .aresetn(aresetn),
    .write_en(wr(uart_reset_pkg::off_transmit_trigger_level)), .write_data(w_byte),
    .value(transmit_trigger_level));
  reset_reg #(.reset_value(uart_reset_pkg::rst_zero)) receive_trigger_reg (
    .aclk(aclk), .aresetn(aresetn),
    .write_en(wr(uart_reset_pkg::off_receive_trigger_level)), .write_data(w_byte),
    .value(receive_trigger_level));
  reset_reg #(.reset_value(uart_reset_pkg::rst_zero)) resume_one_reg (
    .aclk(aclk), .aresetn(aresetn),
    .write_en(wr(uart_reset_pkg::off_resume_char_one)), .write_data(w_byte),
    .value(resume_char_one));
  reset_reg #(.reset_value(uart_reset_pkg::rst_zero)) resume_two_reg (
    .aclk(aclk), .aresetn(aresetn),
    .write_en(wr(uart_reset_pkg::off_resume_char_two)), .write_data(w_byte),
    .value(resume_char_two));
  reset_reg #(.reset_value(uart_reset_pkg::rst_zero)) pause_one_reg (
    .aclk(aclk), .aresetn(aresetn),
    .write_en(wr(uart_reset_pkg::off_pause_char_one)), .write_data(w_byte),
    .value(pause_char_one));
  reset_reg #(.reset_value(uart_reset_pkg::rst_zero)) pause_two_reg (
    .aclk(aclk), .aresetn(aresetn),
    .write_en(wr(uart_reset_pkg::off_pause_char_two)), .write_data(w_byte),
    .value(pause_char_two));

  // Event register: software posts pause/resume event flags in bits 0 to 3, no storage
  assign control_event = wr(uart_reset_pkg::off_control_event) ? w_byte : 8'h00;
  assign flow_enabled = (enhanced_feature[3:0] != 4'h0);

  always_comb
  begin
    next_flow_char_status = flow_char_status;
    // Read clears first, so a same-cycle event still lands
    if (do_read && s_axi_araddr == uart_reset_pkg::off_flow_char_status)
      next_flow_char_status = '0;
    if (control_event[uart_reset_pkg::pause_bit])
    begin
      next_flow_char_status[uart_reset_pkg::pause_bit] = 1'b1;
      next_flow_char_status[uart_reset_pkg::resume_bit] = 1'b0;
    end
    if (control_event[uart_reset_pkg::resume_bit])
    begin
      next_flow_char_status[uart_reset_pkg::resume_bit] = 1'b1;
      next_flow_char_status[uart_reset_pkg::pause_bit] = 1'b0;
    end
    if (control_event[uart_reset_pkg::sent_pause_bit])
    begin
      next_flow_char_status[uart_reset_pkg::sent_pause_bit] = 1'b1;
      next_flow_char_status[uart_reset_pkg::sent_resume_bit] = 1'b0;
    end
    if (control_event[uart_reset_pkg::sent_resume_bit])
    begin
      next_flow_char_status[uart_reset_pkg::sent_resume_bit] = 1'b1;
      next_flow_char_status[uart_reset_pkg::sent_pause_bit] = 1'b0;
    end
    if (!flow_enabled)
      next_flow_char_status = '0;
    if (!aresetn)
      next_flow_char_status = '0;
  end

  always_comb
  begin
    next_transmit_holding = transmit_holding;
    // No reset term: content is undefined after reset
    if (wr(uart_reset_pkg::off_holding))
      next_transmit_holding = w_byte;
    next_modem_last = modem_now;
    next_modem_delta = modem_delta | (modem_now ^ modem_last);
    if (do_read && s_axi_araddr == uart_reset_pkg::off_modem_status)
      next_modem_delta = modem_now ^ modem_last;
    if (!aresetn)
    begin
      next_modem_delta = '0;
      next_modem_last = modem_now; // Tracks the pins so release shows no false delta
    end
  end

  always_ff @(posedge aclk)
  begin
    flow_char_status <= next_flow_char_status;
    transmit_holding <= next_transmit_holding;
    modem_last <= next_modem_last;
    modem_delta <= next_modem_delta;
  end

  always_comb
  begin
    read_hit = 1'b1;
    unique case (s_axi_araddr)
      uart_reset_pkg::off_divisor_low: read_byte = divisor_low;
      uart_reset_pkg::off_divisor_high: read_byte = divisor_high;
      uart_reset_pkg::off_divisor_fraction: read_byte = divisor_fraction;
      uart_reset_pkg::off_holding: read_byte = uart_reset_pkg::rst_zero;
      uart_reset_pkg::off_interrupt_enable: read_byte = interrupt_enable;
      uart_reset_pkg::off_interrupt_status:
        read_byte = uart_reset_pkg::rst_interrupt_status;
      uart_reset_pkg::off_line_control: read_byte = line_control;
      uart_reset_pkg::off_modem_control: read_byte = modem_control;
      uart_reset_pkg::off_line_status: read_byte = uart_reset_pkg::rst_line_status;
      uart_reset_pkg::off_modem_status: read_byte = {modem_now, modem_delta};
      uart_reset_pkg::off_scratchpad: read_byte = scratchpad;
      uart_reset_pkg::off_feature_control: read_byte = feature_control;
      uart_reset_pkg::off_enhanced_feature: read_byte = enhanced_feature;
      uart_reset_pkg::off_transmit_fifo_level: read_byte = uart_reset_pkg::rst_zero;
      uart_reset_pkg::off_receive_fifo_level: read_byte = uart_reset_pkg::rst_zero;
      uart_reset_pkg::off_flow_char_status: read_byte = {4'h0, flow_char_status};
      default:
      begin
        read_byte = 8'h00;
        read_hit = 1'b0;
      end
    endcase
  end

  assign do_read = s_axi_arvalid && s_axi_arready;

  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_byte = w_byte;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      // Lane 0 strobe off writes zero: partial writes are not kept
      next_w_byte = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
    end
    if (do_write)
    begin
      next_bvalid = 1'b1;
      next_bresp = uart_reset_pkg::resp_okay;
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
    end
    if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    if (do_read)
    begin
      next_rvalid = 1'b1;
      next_rdata = {24'h000000, read_byte};
      next_rresp = read_hit ? uart_reset_pkg::resp_okay : uart_reset_pkg::resp_slverr;
    end
    if (s_axi_rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    if (!aresetn)
    begin
      next_aw_held = 1'b0;
      next_aw_addr = 8'h00;
      next_w_held = 1'b0;
      next_w_byte = 8'h00;
      next_bvalid = 1'b0;
      next_bresp = uart_reset_pkg::resp_okay;
      next_rvalid = 1'b0;
      next_rresp = uart_reset_pkg::resp_okay;
      next_rdata = 32'h00000000;
    end
  end

  always_ff @(posedge aclk)
  begin
    aw_held <= next_aw_held;
    aw_addr <= next_aw_addr;
    w_held <= next_w_held;
    w_byte <= next_w_byte;
    s_axi_bvalid <= next_bvalid;
    s_axi_bresp <= next_bresp;
    s_axi_rvalid <= next_rvalid;
    s_axi_rresp <= next_rresp;
    s_axi_rdata <= next_rdata;
  end

  // Ready flags are registered so every output comes from a flop
  always_ff @(posedge aclk)
  begin
    s_axi_awready <= aresetn && !next_aw_held && !next_bvalid;
    s_axi_wready <= aresetn && !next_w_held && !next_bvalid;
    s_axi_arready <= aresetn && !next_rvalid && !(s_axi_arvalid && s_axi_arready);
  end

  // Pins: idle levels; a real transmitter would override these outside reset
  always_comb
  begin
    next_serial = 8'hff;
    next_infrared = 8'h00;
    next_rts_n = 8'hff;
    next_dtr_n = 8'hff;
    next_ee_clock = 1'b0;
    next_ee_select = 1'b0;
    next_ee_data = 1'b0;
  end

  // Idle values are registered too, so they hold from the first reset edge
  always_ff @(posedge aclk)
  begin
    serial_transmit_out <= next_serial;
    infrared_transmit_out <= next_infrared;
    request_to_send_n <= next_rts_n;
    data_terminal_ready_n <= next_dtr_n;
    eeprom_clock_out <= next_ee_clock;
    eeprom_select_out <= next_ee_select;
    eeprom_serial_in_out <= next_ee_data;
  end

  rst_divisor_a: assert property (@(posedge aclk) !aresetn |=> divisor_low == 8'h01 &&
    divisor_high == 8'h00 && divisor_fraction == 8'h00) else $error("divisor reset wrong");
  rst_scratch_a: assert property (@(posedge aclk) !aresetn |=> scratchpad == 8'hff)
    else $error("scratchpad reset wrong");
  rst_ctrl_a: assert property (@(posedge aclk) !aresetn |=> (interrupt_enable |
    line_control | modem_control | enhanced_feature) == 8'h00) else $error("control reset wrong");
  rst_flow_a: assert property (@(posedge aclk) !aresetn |=> flow_char_status == '0 &&
    modem_delta == '0) else $error("status reset wrong");
  flow_off_a: assert property (@(posedge aclk) disable iff (!aresetn) !flow_enabled
    |=> flow_char_status == '0) else $error("flow status not cleared");
  pause_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    control_event[0] && flow_enabled ##1 flow_enabled |-> flow_char_status[0])
    else $error("pause bit not set");
  read_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) do_read &&
    s_axi_araddr == uart_reset_pkg::off_flow_char_status && control_event == 8'h00 |=>
    flow_char_status == '0) else $error("read did not clear");
  pins_idle_a: assert property (@(posedge aclk) ##1 serial_transmit_out == 8'hff &&
    request_to_send_n == 8'hff && data_terminal_ready_n == 8'hff &&
    infrared_transmit_out == 8'h00 && !eeprom_clock_out) else $error("pin idle level wrong");
  read_line_a: assert property (@(posedge aclk) disable iff (!aresetn) do_read &&
    s_axi_araddr == uart_reset_pkg::off_line_status |=> s_axi_rvalid &&
    s_axi_rdata == 32'h00000060) else $error("line status read wrong");
endmodule
`default_nettype wire

//--- bench/uart_far_side_model.sv
// Purpose: Far-side stand-in for one channel: modem pin levels and line watch
// Assumes: Modem levels stay static between bench updates
// Notes: Sends no frames; the line and EEPROM select are only watched for idle
`timescale 1ns/1ps
`default_nettype none
module uart_far_side_model (
  input wire logic [3:0] levels,
  input wire logic [7:0] serial_transmit_out,
  input wire logic eeprom_select_out,
  output logic [3:0] modem_inputs,
  output logic line_idle
);
  // Pins follow the requested levels at once; glitches are not modelled
  assign modem_inputs = levels;
  assign line_idle = (serial_transmit_out === 8'hff) && (eeprom_select_out === 1'b0);
endmodule
`default_nettype wire

//--- bench/uart_channel_reset_defaults_bench.sv
// Purpose: Register and pin checks of the UART channel reset-default block
// Assumes: AXI4-Lite master tasks; the far-side model drives the modem pins
// Notes: Write-only registers other than holding (OKAY, zero), and unmapped places, read back SLVERR with zero data
`timescale 1ns/1ps
`default_nettype none
module uart_channel_reset_defaults_bench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic eeprom_clock_out, eeprom_select_out, eeprom_serial_in_out, line_idle;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0] s_axi_wstrb, modem_inputs, levels;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
  logic [7:0] serial_transmit_out, infrared_transmit_out, request_to_send_n, data_terminal_ready_n;
  int mismatches = 0;
  int samples_checked = 0;

  uart_channel_reset_defaults i_uart_channel_reset_defaults (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .modem_inputs(modem_inputs),
    .serial_transmit_out(serial_transmit_out), .infrared_transmit_out(infrared_transmit_out),
    .request_to_send_n(request_to_send_n), .data_terminal_ready_n(data_terminal_ready_n),
    .eeprom_clock_out(eeprom_clock_out), .eeprom_select_out(eeprom_select_out),
    .eeprom_serial_in_out(eeprom_serial_in_out));

  uart_far_side_model i_uart_far_side_model (.levels(levels),
    .serial_transmit_out(serial_transmit_out), .eeprom_select_out(eeprom_select_out),
    .modem_inputs(modem_inputs), .line_idle(line_idle));

  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic stop_test;
    begin
      if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    begin
      samples_checked++;
      if (got !== exp)
      begin
        mismatches++;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task automatic timeout(input int n);
    begin
      if (n > 200)
      begin
        mismatches++;
        stop_test();
      end
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    bit aw_done;
    bit w_done;
    begin
      n = 0;
      aw_done = 0;
      w_done = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_done && w_done))
      begin
        @(posedge aclk);
        if (!aw_done && s_axi_awready === 1'b1)
        begin
          aw_done = 1;
          s_axi_awvalid <= 1'b0;
        end
        if (!w_done && s_axi_wready === 1'b1)
        begin
          w_done = 1;
          s_axi_wvalid <= 1'b0;
        end
        timeout(++n);
      end
      // bready stays high until the response is sampled
      while (s_axi_bvalid !== 1'b1 || n == 0)
      begin
        n = (n == 0) ? 1 : n;
        @(posedge aclk);
        timeout(++n);
        if (s_axi_bvalid === 1'b1) n = -1;
        if (n < 0) break;
      end
      check({30'h0, s_axi_bresp}, {30'h0, uart_reset_pkg::resp_okay});
      s_axi_bready <= 1'b0;
    end
  endtask

  task automatic axi_read(input logic [7:0] a);
    int n;
    begin
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
        @(posedge aclk);
        timeout(++n);
      end
      while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do
      begin
        @(posedge aclk);
        timeout(++n);
      end
      while (s_axi_rvalid !== 1'b1);
      rd_data = s_axi_rdata;
      rd_resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] resp);
    begin
      axi_read(a);
      check(rd_data, exp);
      check({30'h0, rd_resp}, {30'h0, resp});
    end
  endtask

  task automatic pins_idle;
    begin
      check({serial_transmit_out, infrared_transmit_out}, 32'h0000ff00);
      check({request_to_send_n, data_terminal_ready_n}, 32'h0000ffff);
      check({eeprom_clock_out, eeprom_select_out, eeprom_serial_in_out, line_idle},
        32'h1);
    end
  endtask

  task automatic defaults;
    begin
      rchk(uart_reset_pkg::off_divisor_low, 32'h01, uart_reset_pkg::resp_okay);
      rchk(uart_reset_pkg::off_divisor_high, 32'h00, uart_reset_pkg::resp_okay);
      rchk(uart_reset_pkg::off_divisor_fraction, 32'h00, uart_reset_pkg::resp_okay);
      rchk(uart_reset_pkg::off_interrupt_status, 32'h01, uart_reset_pkg::resp_okay);
      rchk(uart_reset_pkg::off_line_status, 32'h60, uart_reset_pkg::resp_okay);
      rchk(uart_reset_pkg::off_modem_status, {24'h0, levels, 4'h0}, 2'h0);
      rchk(uart_reset_pkg::off_scratchpad, 32'hff, uart_reset_pkg::resp_okay);
      rchk(uart_reset_pkg::off_interrupt_enable, 32'h00, uart_reset_pkg::resp_okay);
      rchk(uart_reset_pkg::off_line_control, 32'h00, uart_reset_pkg::resp_okay);
      rchk(uart_reset_pkg::off_modem_control, 32'h00, uart_reset_pkg::resp_okay);
      rchk(uart_reset_pkg::off_feature_control, 32'h00, uart_reset_pkg::resp_okay);
      rchk(uart_reset_pkg::off_enhanced_feature, 32'h00, uart_reset_pkg::resp_okay);
      rchk(uart_reset_pkg::off_transmit_fifo_level, 32'h00, uart_reset_pkg::resp_okay);
      rchk(uart_reset_pkg::off_receive_fifo_level, 32'h00, uart_reset_pkg::resp_okay);
      rchk(uart_reset_pkg::off_flow_char_status, 32'h00, uart_reset_pkg::resp_okay);
      // Holding content is undefined after reset: only the response is compared
      axi_read(uart_reset_pkg::off_holding);
      check({30'h0, rd_resp}, {30'h0, uart_reset_pkg::resp_okay});
    end
  endtask

  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    levels = 4'ha;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    #1 pins_idle();
    defaults();
    rchk(uart_reset_pkg::off_pause_char_one, 32'h0, uart_reset_pkg::resp_slverr);
    rchk(8'h60, 32'h0, uart_reset_pkg::resp_slverr);
    axi_write(uart_reset_pkg::off_enhanced_feature, 32'h02);
    axi_write(uart_reset_pkg::off_control_event, 32'h02);
    axi_write(uart_reset_pkg::off_control_event, 32'h01);
    rchk(uart_reset_pkg::off_flow_char_status, 32'h01, uart_reset_pkg::resp_okay);
    rchk(uart_reset_pkg::off_flow_char_status, 32'h00, uart_reset_pkg::resp_okay);
    axi_write(uart_reset_pkg::off_control_event, 32'h01);
    axi_write(uart_reset_pkg::off_enhanced_feature, 32'h00);
    rchk(uart_reset_pkg::off_flow_char_status, 32'h00, uart_reset_pkg::resp_okay);
    axi_write(uart_reset_pkg::off_scratchpad, 32'h5a);
    axi_write(uart_reset_pkg::off_divisor_low, 32'h07);
    axi_write(uart_reset_pkg::off_line_status, 32'h00);
    rchk(uart_reset_pkg::off_scratchpad, 32'h5a, uart_reset_pkg::resp_okay);
    rchk(uart_reset_pkg::off_line_status, 32'h60, uart_reset_pkg::resp_okay);
    // Second reset in mid-run, with software values in place
    @(posedge aclk);
    aresetn <= 1'b0;
    @(posedge aclk);
    #1 pins_idle();
    @(posedge aclk);
    aresetn <= 1'b1;
    defaults();
    levels <= 4'h5;
    repeat (4) @(posedge aclk);
    axi_read(uart_reset_pkg::off_modem_status);
    check({28'h0, rd_data[7:4]}, 32'h5);
    stop_test();
  end
endmodule
`default_nettype wire
